/* flash_sector_erase_key_unlock_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module flash_sector_erase_key_unlock_tb;
   import fsk_pkg::*;
   logic        clk_in, rst_n_in, psel_in, penable_in, pwrite_in;
   logic        special_single_chip_in, bdm_active_in, er;
   logic        pready_out, pslverr_out, erase_start_out;
   logic        erase_busy_out, unsecured_out, key_locked_out;
   logic [7:0]  paddr_in, security_byte_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic [15:0] flash_addr_out, flash_rdata_in, ad;
   logic [63:0] backdoor_key_in, key;
   logic [6:0]  erase_sector_out, sect;
   integer      seed = 24327;
   integer      mismatches = 0;
   integer      num_checks = 0;
   integer      starts = 0;
   integer      i, j, n, s0;

   fsk_top #(.ERASE_CYCLES(16)) u_fsk_top (.*);

   // ==========================================================
   // Clock, start-pulse monitor, watchdog
   // ==========================================================
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      if (erase_start_out === 1'b1) begin
         starts <= starts + 1;
         sect   <= erase_sector_out;
      end
   end

   // Whole run is well under a thousand cycles; this (20000 cycles) is far beyond it
   initial begin
      #80000;
      mismatches = mismatches + 1;
      test_done;
   end

   // ==========================================================
   // Tasks and expectation helpers
   // ==========================================================
   task automatic chk(input logic [31:0] g, e, input string m);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // Holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_in);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= w;
      paddr_in   <= a;
      pwdata_in  <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 50);
      rd = prdata_out;
      er = pslverr_out;
      if (n >= 50) begin
         mismatches++;
         test_done;
      end
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                        input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask

   function automatic logic [31:0] stx(input logic cc, pv, ac, bz);
      stx = {24'h0, 1'b1, cc, pv, ac, 3'h0, bz};
   endfunction

   function automatic logic [15:0] fw(input logic [15:0] w);
      fw = (w == KEY_ZERO || w == KEY_ONES) ? 16'h5A5A : w;
   endfunction

   task automatic erase(input logic [15:0] a);
      apb(1'b1, ADDR_ARR_ADDR, {16'h0, a});
      apb(1'b1, ADDR_ARR_DATA, $random(seed));
      apb(1'b1, ADDR_CMD, {24'h0, CMD_SECT_ERASE});
      apb(1'b1, ADDR_STAT, 32'h80);
   endtask

   task automatic keyseq(input logic [63:0] w, input int nw = 4);
      apb(1'b1, ADDR_CFG, 32'h1);
      apb(1'b0, ADDR_ARR_DATA, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, INVALID_DATA}, "array read");
      for (i = 0; i < nw; i++) begin
         apb(1'b1, ADDR_ARR_ADDR, {16'h0, KEY_BASE + 16'(2 * i)});
         apb(1'b1, ADDR_ARR_DATA, {16'h0, w[16 * (i % 4) +: 16]});
      end
      apb(1'b1, ADDR_CFG, 32'h0);
      repeat (3) @(posedge clk_in);
   endtask

   task automatic do_reset;
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      rst_n_in = 1'b0;
      psel_in = 1'b0;
      penable_in = 1'b0;
      pwrite_in = 1'b0;
      paddr_in = 8'h00;
      pwdata_in = 32'h0;
      special_single_chip_in = 1'b0;
      bdm_active_in = 1'b0;
      security_byte_in = 8'h80;
      flash_rdata_in = 16'(fw(16'($random(seed))));
      for (j = 0; j < 4; j++) key[16 * j +: 16] = fw(16'($random(seed)));
      backdoor_key_in = key;
      do_reset;
      rdchk(ADDR_STAT, stx(1, 0, 0, 0), "stat after reset");
      rdchk(ADDR_ARR_DATA, {16'h0, flash_rdata_in}, "array data");
      apb(1'b0, 8'h1C, 32'h0);
      chk(er, 1, "unmapped slverr");
      apb(1'b1, ADDR_PROT, 32'hC0);
      for (j = 0; j < 4; j++) begin
         ad = 16'($random(seed)) & 16'h7FFF;
         s0 = starts;
         erase(ad);
         rdchk(ADDR_STAT, stx(0, 0, 0, 1), "launch stat");
         chk(erase_busy_out, 1, "busy pin");
         chk(flash_addr_out, ad, "array address pin");
         repeat (20) @(posedge clk_in);
         chk(starts, s0 + 1, "one start");
         chk(sect, ad[15:9], "sector");
         chk(erase_busy_out, 0, "busy over");
         rdchk(ADDR_STAT, stx(1, 0, 0, 0), "erase done");
      end
      // Second launch while the first still runs is buffered
      s0 = starts;
      erase(16'($random(seed)) & 16'h7FFF);
      ad = 16'($random(seed)) & 16'h7FFF;
      erase(ad);
      rdchk(ADDR_STAT, 32'h01, "buffered");
      repeat (6) @(posedge clk_in);
      rdchk(ADDR_STAT, stx(0, 0, 0, 1), "no complete yet");
      repeat (20) @(posedge clk_in);
      chk(starts, s0 + 2, "two starts");
      chk(sect, ad[15:9], "buffered sector");
      rdchk(ADDR_STAT, stx(1, 0, 0, 0), "both done");
      // Sectors at or above the threshold are protected
      s0 = starts;
      erase(16'h8000 | 16'($random(seed)));
      repeat (12) @(posedge clk_in);
      chk(starts, s0, "protected no start");
      rdchk(ADDR_STAT, stx(1, 1, 0, 0), "protection_violation_flag set");
      apb(1'b1, ADDR_STAT, 32'h20);
      rdchk(ADDR_STAT, stx(1, 0, 0, 0), "protection_violation_flag clear");
      apb(1'b1, ADDR_ARR_ADDR, 32'h0200);
      apb(1'b1, ADDR_ARR_DATA, 32'h0);
      apb(1'b1, ADDR_CMD, 32'h41);
      rdchk(ADDR_STAT, stx(1, 0, 1, 0), "bad opcode");
      apb(1'b1, ADDR_STAT, 32'h10);
      rdchk(ADDR_SEC, 32'h80, "secured");
      keyseq(key);
      chk(unsecured_out, 1, "key unlock");
      rdchk(ADDR_SEC, 32'h82, "sec forced");
      rdchk(ADDR_PROT, 32'hC0, "prot kept");
      apb(1'b1, ADDR_ARR_ADDR, {16'h0, KEY_BASE});
      apb(1'b1, ADDR_ARR_DATA, 32'h1357);
      rdchk(ADDR_STAT, stx(1, 0, 0, 0), "key reprogram ok");
      do_reset;
      chk(unsecured_out, 0, "byte reloaded");
      apb(1'b1, ADDR_ARR_ADDR, {16'h0, KEY_BASE});
      apb(1'b1, ADDR_ARR_DATA, 32'h1357);
      rdchk(ADDR_STAT, stx(1, 0, 1, 0), "key area guarded");
      apb(1'b1, ADDR_STAT, 32'h10);
      keyseq(key ^ 64'h10000);
      chk(key_locked_out, 1, "mismatch locks");
      keyseq(key);
      chk(unsecured_out, 0, "lock holds");
      do_reset;
      chk(key_locked_out, 0, "reset unlocks");
      backdoor_key_in <= {key[63:16], KEY_ONES};
      keyseq({key[63:16], KEY_ONES});
      chk(key_locked_out, 1, "forbidden word");
      backdoor_key_in <= key;
      do_reset;
      keyseq(key, 5);
      chk(key_locked_out, 1, "fifth word");
      do_reset;
      keyseq(key, 2);
      chk(key_locked_out, 1, "enable dropped");
      do_reset;
      special_single_chip_in <= 1'b1;
      bdm_active_in <= 1'b1;
      keyseq(key);
      chk(unsecured_out, 0, "debug refused");
      special_single_chip_in <= 1'b0;
      bdm_active_in <= 1'b0;
      security_byte_in <= 8'h40;
      do_reset;
      keyseq(key);
      chk(unsecured_out, 0, "unlock disabled");
      test_done;
   end
endmodule

`default_nettype wire

/* fsk_key_fsm.sv */
`timescale 1ns/1ps
`default_nettype none

module fsk_key_fsm
   import fsk_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        key_mode_in,
   input  wire logic        wr_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] data_in,
   input  wire logic [63:0] key_in,
   input  wire logic        allowed_in,
   output logic             unsecure_out,
   output logic             locked_out
);

   fsk_key_t   state_reg;
   fsk_key_t   state_next;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic       unsec_next;

   wire logic [15:0] exp_addr  = KEY_BASE + {13'h0000, cnt_reg[1:0], 1'b0};
   wire logic [15:0] key_word  = key_in[{cnt_reg[1:0], 4'h0} +: 16];
   wire logic        forbidden = (data_in == KEY_ZERO) ||
                                 (data_in == KEY_ONES);
   wire logic        word_bad  = (addr_in != exp_addr) ||
                                 (data_in != key_word) || forbidden ||
                                 (cnt_reg == KEY_WORDS);
   wire logic        all_in    = (cnt_reg == KEY_WORDS);

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unsec_next = 1'b0;
      unique case (state_reg)
         KEY_IDLE: begin
            if (key_mode_in) begin
               state_next = KEY_COLLECT;
               cnt_next   = 3'h0;
            end
         end
         KEY_COLLECT: begin
            if (!key_mode_in) begin
               // Enable dropped: clean finish only after all words
               if (all_in) begin
                  state_next = KEY_IDLE;
                  unsec_next = allowed_in;
               end else if (cnt_reg != 3'h0) begin
                  state_next = KEY_LOCKED;
               end else begin
                  state_next = KEY_IDLE;
               end
            end else if (wr_in) begin
               if (word_bad) begin
                  state_next = KEY_LOCKED;
               end else begin
                  cnt_next = cnt_reg + 3'h1;
               end
            end
         end
         KEY_LOCKED: begin
            // Only a device reset leaves this state
            state_next = KEY_LOCKED;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg    <= KEY_IDLE;
         cnt_reg      <= 3'h0;
         unsecure_out <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         unsecure_out <= unsec_next;
      end
   end

   assign locked_out = (state_reg == KEY_LOCKED);

   // ==========================================================
   // Assertions
   // ==========================================================
   fifth_word_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_reg == KEY_COLLECT && key_mode_in && wr_in &&
       cnt_reg == KEY_WORDS) |=> locked_out)
      else $error("fifth key word did not lock");

   forbid_word_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_reg == KEY_COLLECT && key_mode_in && wr_in &&
       (data_in == KEY_ZERO || data_in == KEY_ONES)) |=> locked_out)
      else $error("forbidden key word accepted");

   lock_hold_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      locked_out |=> locked_out && !unsecure_out)
      else $error("lock state left without reset");

   drop_lock_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_reg == KEY_COLLECT && !key_mode_in &&
       cnt_reg != 3'h0 && cnt_reg != KEY_WORDS) |=> locked_out)
      else $error("early enable drop did not lock");

   unsec_cause_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      unsecure_out |-> $past(cnt_reg) == KEY_WORDS &&
                       $past(allowed_in) && !$past(key_mode_in))
      else $error("unsecure without four good words");

   key_ok_c: cover property (
      @(posedge clk_in) disable iff (!rst_n_in) unsecure_out);

   key_lock_c: cover property (
      @(posedge clk_in) disable iff (!rst_n_in) $rose(locked_out));

endmodule

`default_nettype wire

/* fsk_pkg.sv */
package fsk_pkg;

   // ==========================================================
   // Register offsets (byte addresses on the register bus)
   // ==========================================================
   localparam logic [7:0]  ADDR_CFG      = 8'h00;
   localparam logic [7:0]  ADDR_SEC      = 8'h04;
   localparam logic [7:0]  ADDR_PROT     = 8'h08;
   localparam logic [7:0]  ADDR_STAT     = 8'h0C;
   localparam logic [7:0]  ADDR_CMD      = 8'h10;
   localparam logic [7:0]  ADDR_ARR_ADDR = 8'h14;
   localparam logic [7:0]  ADDR_ARR_DATA = 8'h18;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int          CFG_KEY_BIT   = 0;
   localparam int          SEC_KEY_UNLOCK_ENABLE_LSB = 6;
   localparam int          SEC_STATE_LSB = 0;
   localparam int          STAT_CMD_BUFFER_EMPTY_FLAG    = 7;
   localparam int          STAT_CMD_COMPLETE_FLAG     = 6;
   localparam int          STAT_PROTECTION_VIOLATION_FLAG    = 5;
   localparam int          STAT_ACCESS_ERROR_FLAG   = 4;
   localparam int          STAT_BUSY     = 0;
   localparam int          PROT_EN_BIT   = 7;
   localparam int          SECTOR_LSB    = 9;

   // ==========================================================
   // Reset values, codes and timing
   // ==========================================================
   localparam logic [7:0]  CFG_RST        = 8'h00;
   localparam logic [7:0]  PROT_RST       = 8'h00;
   localparam logic [7:0]  CMD_RST        = 8'h00;
   localparam logic [7:0]  CMD_SECT_ERASE = 8'h40;
   localparam logic [15:0] KEY_BASE       = 16'hFF00;
   localparam logic [15:0] KEY_ZERO       = 16'h0000;
   localparam logic [15:0] KEY_ONES       = 16'hFFFF;
   localparam logic [15:0] INVALID_DATA   = 16'hFFFF;
   localparam logic [1:0]  KEY_UNLOCK_ENABLE_ON       = 2'h2;
   localparam logic [1:0]  SEC_UNSECURE   = 2'h2;
   localparam logic [2:0]  KEY_WORDS      = 3'h4;
   // Erase duration: not specified, default is a plain choice
   localparam int          ERASE_CYCLES_DEF = 1000;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_ADDR,
      SEQ_CMD
   } fsk_seq_t;

   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_COLLECT,
      KEY_LOCKED
   } fsk_key_t;

endpackage

/* fsk_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Sector erase clears one 512-byte sector alone
// - Sector from array address; bits 15:9, data ignored
// - Writing one to buffer-empty flag launches
// - Protected sector sets violation flag, no launch
// - Complete flag sets at end unless buffered
// - Key words 0x0000, 0xFFFF never accepted
// - Array reads invalid while key-write enabled
// - Key unlock only when unlock field is 1:0
// - Good key sequence forces security state 1:0
// - Illegal key operation locks the state machine
// - Device reset releases the lock state
// - Mismatch, order, fifth, forbidden, enable drop lock
// - Security byte untouched; reloaded after reset
// - Stored key words untouched by key sequence
// - Protection settings untouched by key sequence
// - No unsecure via debug in special single chip
// - Unsecured device may reprogram key words
// - Launch clears complete flag, re-sets buffer-empty
module fsk_top
   import fsk_pkg::*;
#(
   parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
)(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic [15:0]      flash_addr_out,
   input  wire logic [15:0] flash_rdata_in,
   input  wire logic [63:0] backdoor_key_in,
   input  wire logic [7:0]  security_byte_in,
   input  wire logic        special_single_chip_in,
   input  wire logic        bdm_active_in,
   output logic             erase_start_out,
   output logic [6:0]       erase_sector_out,
   output logic             erase_busy_out,
   output logic             unsecured_out,
   output logic             key_locked_out
);

   localparam logic [15:0] ERASE_LAST = 16'(ERASE_CYCLES - 1);

   // ==========================================================
   // Register bus decode
   // ==========================================================
   logic [7:0]  cfg_reg;
   logic [7:0]  prot_reg;
   logic [7:0]  cmd_reg;
   logic [15:0] arr_addr_reg;
   logic [1:0]  key_unlock_enable_reg;
   logic [1:0]  sec_state_reg;
   logic        sec_load_reg;
   logic        cmd_buffer_empty_flag_reg;
   logic        cmd_complete_flag_reg;
   logic        protection_violation_flag_reg;
   logic        access_error_flag_reg;
   fsk_seq_t    step_reg;
   logic [15:0] buf_addr_reg;
   logic        busy_reg;
   logic [15:0] cnt_reg;
   logic        pend_reg;
   logic [6:0]  pend_sector_reg;
   logic        key_unsecure;
   logic        key_locked;

   wire logic sel_cfg  = (paddr_in == ADDR_CFG);
   wire logic sel_sec  = (paddr_in == ADDR_SEC);
   wire logic sel_prot = (paddr_in == ADDR_PROT);
   wire logic sel_stat = (paddr_in == ADDR_STAT);
   wire logic sel_cmd  = (paddr_in == ADDR_CMD);
   wire logic sel_aadr = (paddr_in == ADDR_ARR_ADDR);
   wire logic sel_adat = (paddr_in == ADDR_ARR_DATA);
   wire logic mapped   = sel_cfg | sel_sec | sel_prot | sel_stat |
                         sel_cmd | sel_aadr | sel_adat;

   wire logic access   = psel_in & penable_in;
   wire logic setup_rd = psel_in & ~penable_in & ~pwrite_in;
   wire logic wr_en    = access & pwrite_in & mapped;

   wire logic key_mode = cfg_reg[CFG_KEY_BIT];
   wire logic arr_wr   = wr_en & sel_adat;
   wire logic cmd_wr   = wr_en & sel_cmd;
   wire logic stat_wr  = wr_en & sel_stat;
   wire logic launch_wr = stat_wr & pwdata_in[STAT_CMD_BUFFER_EMPTY_FLAG];
   wire logic flag_err = protection_violation_flag_reg | access_error_flag_reg;

   // ==========================================================
   // Command sequencing
   // ==========================================================
   wire logic key_area  = (arr_addr_reg[15:3] == KEY_BASE[15:3]);
   wire logic unsecured = (sec_state_reg == SEC_UNSECURE);
   // Key words are writable only once the device is unsecured
   wire logic key_guard = key_area & ~unsecured;
   wire logic seq_wr    = arr_wr & ~key_mode & ~flag_err &
                          ~key_guard;
   wire logic guard_err = arr_wr & ~key_mode & ~flag_err & key_guard;
   wire logic cmd_ok    = cmd_wr & (step_reg == SEQ_ADDR) &
                          (pwdata_in[7:0] == CMD_SECT_ERASE);
   wire logic cmd_bad   = cmd_wr & ~cmd_ok;
   wire logic abort_wr  = stat_wr & ~pwdata_in[STAT_CMD_BUFFER_EMPTY_FLAG] &
                          (step_reg != SEQ_IDLE);
   wire logic [6:0] sector = buf_addr_reg[15:SECTOR_LSB];
   wire logic prot_hit_s = prot_reg[PROT_EN_BIT] &
                           (sector >= prot_reg[6:0]);
   wire logic armed     = launch_wr & (step_reg == SEQ_CMD) &
                          cmd_buffer_empty_flag_reg;
   wire logic prot_hit  = armed & prot_hit_s;
   wire logic launch_ok = armed & ~prot_hit_s;
   wire logic acc_set   = guard_err | cmd_bad | abort_wr;

   // ==========================================================
   // Erase engine
   // ==========================================================
   wire logic done_w    = busy_reg & (cnt_reg == 16'h0000);
   wire logic free_now  = ~busy_reg | (done_w & ~pend_reg);
   wire logic start_new = launch_ok & free_now;
   wire logic start_pnd = done_w & pend_reg;
   wire logic pend_set  = launch_ok & ~free_now;
   wire logic cmd_complete_flag_set  = done_w & ~pend_reg & ~launch_ok;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         step_reg     <= SEQ_IDLE;
         buf_addr_reg <= 16'h0000;
         cmd_reg      <= CMD_RST;
      end else begin
         if (launch_ok || prot_hit || abort_wr || cmd_bad) begin
            step_reg <= SEQ_IDLE;
         end else if (seq_wr) begin
            // A new array write restarts the sequence
            step_reg     <= SEQ_ADDR;
            buf_addr_reg <= arr_addr_reg;
         end else if (cmd_ok) begin
            step_reg <= SEQ_CMD;
            cmd_reg  <= pwdata_in[7:0];
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_reg         <= 1'b0;
         cnt_reg          <= 16'h0000;
         pend_reg         <= 1'b0;
         pend_sector_reg  <= 7'h00;
         erase_start_out  <= 1'b0;
         erase_sector_out <= 7'h00;
      end else begin
         erase_start_out <= start_new | start_pnd;
         if (start_new || start_pnd) begin
            busy_reg         <= 1'b1;
            cnt_reg          <= ERASE_LAST;
            erase_sector_out <= start_pnd ? pend_sector_reg : sector;
         end else if (done_w) begin
            busy_reg <= 1'b0;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
         if (pend_set) begin
            pend_reg        <= 1'b1;
            pend_sector_reg <= sector;
         end else if (start_pnd) begin
            pend_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Status flags
   // ==========================================================
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_buffer_empty_flag_reg  <= 1'b1;
         cmd_complete_flag_reg   <= 1'b1;
         protection_violation_flag_reg  <= 1'b0;
         access_error_flag_reg <= 1'b0;
      end else begin
         // Buffer stays busy while a second command waits
         if (launch_ok) begin
            cmd_buffer_empty_flag_reg <= 1'b0;
         end else if (!cmd_buffer_empty_flag_reg && !pend_reg) begin
            cmd_buffer_empty_flag_reg <= 1'b1;
         end
         if (launch_ok) begin
            cmd_complete_flag_reg <= 1'b0;
         end else if (cmd_complete_flag_set) begin
            cmd_complete_flag_reg <= 1'b1;
         end
         // Hardware set wins over a same-cycle software clear
         protection_violation_flag_reg  <= prot_hit |
                       (protection_violation_flag_reg & ~(stat_wr & pwdata_in[STAT_PROTECTION_VIOLATION_FLAG]));
         access_error_flag_reg <= acc_set |
                       (access_error_flag_reg & ~(stat_wr & pwdata_in[STAT_ACCESS_ERROR_FLAG]));
      end
   end

   // ==========================================================
   // Configuration and security
   // ==========================================================
   wire logic key_allowed = (key_unlock_enable_reg == KEY_UNLOCK_ENABLE_ON) & ~sec_load_reg &
                    ~(special_single_chip_in & bdm_active_in);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_reg      <= CFG_RST;
         prot_reg     <= PROT_RST;
         arr_addr_reg <= 16'h0000;
      end else begin
         if (wr_en && sel_cfg) begin
            cfg_reg <= pwdata_in[7:0];
         end
         // Only software writes this; the key path never does
         if (wr_en && sel_prot) begin
            prot_reg <= pwdata_in[7:0];
         end
         if (wr_en && sel_aadr) begin
            arr_addr_reg <= pwdata_in[15:0];
         end
      end
   end

   // Security comes from the options byte once per reset; the key
   // path only overrides the live state, never the stored byte
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sec_load_reg  <= 1'b1;
         key_unlock_enable_reg     <= 2'h0;
         sec_state_reg <= 2'h0;
      end else if (sec_load_reg) begin
         sec_load_reg  <= 1'b0;
         key_unlock_enable_reg     <= security_byte_in[SEC_KEY_UNLOCK_ENABLE_LSB +: 2];
         sec_state_reg <= security_byte_in[SEC_STATE_LSB +: 2];
      end else if (key_unsecure) begin
         sec_state_reg <= SEC_UNSECURE;
      end
   end

   // Key words come in read-only; nothing here writes them back
   fsk_key_fsm u_key (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .key_mode_in  (key_mode),
      .wr_in        (arr_wr & key_mode),
      .addr_in      (arr_addr_reg),
      .data_in      (pwdata_in[15:0]),
      .key_in       (backdoor_key_in),
      .allowed_in   (key_allowed),
      .unsecure_out (key_unsecure),
      .locked_out   (key_locked)
   );

   // ==========================================================
   // Read path and outputs
   // ==========================================================
   wire logic [15:0] arr_rdata = key_mode ? INVALID_DATA
                                          : flash_rdata_in;
   wire logic [7:0]  stat_rd = {cmd_buffer_empty_flag_reg, cmd_complete_flag_reg, protection_violation_flag_reg,
                                access_error_flag_reg, 3'h0, busy_reg};
   wire logic [7:0]  sec_rd  = {key_unlock_enable_reg, 4'h0, sec_state_reg};
   wire logic [31:0] rd_mux  =
      sel_cfg  ? {24'h000000, cfg_reg}  :
      sel_sec  ? {24'h000000, sec_rd}   :
      sel_prot ? {24'h000000, prot_reg} :
      sel_stat ? {24'h000000, stat_rd}  :
      sel_cmd  ? {24'h000000, cmd_reg}  :
      sel_aadr ? {16'h0000, arr_addr_reg} :
      sel_adat ? {16'h0000, arr_rdata}  : 32'h00000000;

   // Data is caught in the setup cycle so the answer needs no wait
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prdata_out <= 32'h00000000;
      end else if (setup_rd) begin
         prdata_out <= rd_mux;
      end
   end

   assign pready_out     = 1'b1;
   assign pslverr_out    = access & ~mapped;
   assign flash_addr_out = arr_addr_reg;
   assign erase_busy_out = busy_reg;
   assign unsecured_out  = unsecured;
   assign key_locked_out = key_locked;

   // ==========================================================
   // Assertions
   // ==========================================================
   launch_clr_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      launch_ok |=> !cmd_complete_flag_reg && !cmd_buffer_empty_flag_reg)
      else $error("launch did not clear flags");

   cmd_buffer_empty_flag_back_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (launch_ok && free_now) |=> ##1 cmd_buffer_empty_flag_reg)
      else $error("buffer-empty not restored");

   prot_block_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      prot_hit |=> protection_violation_flag_reg && !erase_start_out &&
                   (cmd_complete_flag_reg || !$past(cmd_complete_flag_reg)))
      else $error("protected erase launched");

   erase_end_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (done_w && !pend_reg && !launch_ok) |=> cmd_complete_flag_reg && !busy_reg)
      else $error("complete flag missing after erase");

   pend_hold_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      start_pnd |=> !cmd_complete_flag_reg && erase_start_out && busy_reg)
      else $error("buffered erase not started");

   invalid_rd_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (setup_rd && sel_adat && key_mode) |=>
         prdata_out[15:0] == INVALID_DATA)
      else $error("array read valid in key mode");

   unsec_keep_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (key_unsecure && !sec_load_reg && !(wr_en && sel_prot)) |=>
         unsecured_out && prot_reg == $past(prot_reg))
      else $error("unsecure changed protection");

   bdm_refuse_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (special_single_chip_in && bdm_active_in) |=> !key_unsecure)
      else $error("unlock allowed in debug special mode");

   erase_c: cover property (
      @(posedge clk_in) disable iff (!rst_n_in) cmd_complete_flag_set);

   buffered_c: cover property (
      @(posedge clk_in) disable iff (!rst_n_in) pend_set);

   protection_violation_flag_c: cover property (
      @(posedge clk_in) disable iff (!rst_n_in) prot_hit);

endmodule

`default_nettype wire
